// >>> core/bca_pkg.sv
// Constants for the bridge configuration and power management setup registers
package bca_pkg;
    // Configuration byte offsets
    localparam logic [7:0] OFS_REVISION_IDENTIFIER = 8'h08;
    localparam logic [7:0] OFS_PROGRAMMING_INTERFACE_CODE = 8'h09;
    localparam logic [7:0] OFS_SUB_CLASS_CODE = 8'h0a;
    localparam logic [7:0] OFS_BASE_CLASS_CODE = 8'h0b;
    localparam logic [7:0] OFS_HEADER_LAYOUT_TYPE = 8'h0e;
    localparam logic [7:0] OFS_POWER_MGMT_IO_BASE = 8'h40;
    localparam logic [7:0] OFS_POWER_MGMT_CONTROL = 8'h44;

    // Dword indices seen on the configuration port
    localparam logic [5:0] DW_CLASS = OFS_REVISION_IDENTIFIER[7:2];
    localparam logic [5:0] DW_HEADER = OFS_HEADER_LAYOUT_TYPE[7:2];
    localparam logic [5:0] DW_IO_BASE = OFS_POWER_MGMT_IO_BASE[7:2];
    localparam logic [5:0] DW_CONTROL = OFS_POWER_MGMT_CONTROL[7:2];
    localparam logic [1:0] LANE_HEADER = OFS_HEADER_LAYOUT_TYPE[1:0];

    // Fixed values
    localparam logic [7:0] PROGRAMMING_INTERFACE_VALUE = 8'h00;
    localparam logic [7:0] SUB_CLASS_VALUE = 8'h01;
    localparam logic [7:0] BASE_CLASS_VALUE = 8'h06;
    localparam logic [7:0] HEADER_LAYOUT_VALUE = 8'h80;

    // Reset values and writable masks
    localparam logic [31:0] IO_BASE_RESET = 32'h0000_0001;
    localparam logic [7:0] IO_BASE_B0_WMASK = 8'h80;
    localparam logic [7:0] IO_BASE_B1_WMASK = 8'hff;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h17;

    // Field positions
    localparam int IO_BASE_LSB = 7;
    localparam int IO_BASE_MSB = 15;
    localparam int CTRL_DECODE_EN_BIT = 4;
    localparam int CTRL_SEL_MSB = 2;

    // Always-decoded APM control ports
    localparam logic [15:0] APM_CONTROL_PORT = 16'h00b2;
    localparam logic [15:0] APM_STATUS_PORT = 16'h00b3;

    // Interrupt line select codes
    localparam logic [2:0] SEL_IRQ9 = 3'h0;
    localparam logic [2:0] SEL_IRQ10 = 3'h1;
    localparam logic [2:0] SEL_IRQ11 = 3'h2;
    localparam logic [2:0] SEL_RESERVED = 3'h3;
    localparam int SEL_ADVANCED_INTERRUPT_CONTROLLER_BIT = 2;
endpackage : bca_pkg

// >>> core/bca_wr_if.sv
// Byte register write port between the bank and its byte registers
`timescale 1ns/1ps
interface bca_wr_if;
    logic we;
    logic [7:0] wdata;
    logic [7:0] q;
    modport src (output we, output wdata, input q);
    modport sink (input we, input wdata, output q);
endinterface : bca_wr_if

// >>> core/bca_byte_reg.sv
// One configuration byte with a mask of writable bits
`timescale 1ns/1ps
module bca_byte_reg #(
    parameter logic [7:0] WMASK = 8'hff,
    parameter logic [7:0] RESET = 8'h00
) (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_i,   // Async reset, active high
    bca_wr_if.sink port         // Write strobe, data and stored value
);
    // Bits outside the mask keep their reset value
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            port.q <= RESET;
        end else if (port.we) begin
            port.q <= (port.q & ~WMASK) | (port.wdata & WMASK);
        end
    end
endmodule : bca_byte_reg

// >>> core/bca_config_regs.sv
// Bridge configuration header and power management setup registers
// Notes on behaviour
// - Revision identifier byte, read-only, value external
// - Programming interface byte reads zero
// - Sub-class byte reads 01h
// - Base class byte reads 06h
// - Header type bit 7 set: multi-function
// - Header type low seven bits read-only zero
// - Base bits 15:7 writable, 128-byte aligned window
// - Base bit 0 reads one; reserved bits
// - Window holds power, GPIO, cost-logic registers
// - Decode enable gates window and power function
// - APM ports B2h/B3h always decoded
// - With controller, IRQ20-23 allowed and shareable
// - Select field encodes IRQ9-11, reserved, IRQ20-23
`timescale 1ns/1ps
module bca_config_regs #(
    parameter logic [7:0] REVISION_ID = 8'h00 // Arbitrary value, set per silicon
) (
    input wire logic clk_sys_i,           // System clock
    input wire logic reset_i,             // Async platform reset, active high
    input wire logic cfg_req_i,           // Configuration access strobe
    input wire logic cfg_wr_i,            // 1 write, 0 read
    input wire logic [5:0] cfg_dw_i,      // Dword index of access
    input wire logic [3:0] cfg_be_i,      // Byte enables, active high
    input wire logic [31:0] cfg_wdata_i,  // Write data
    output logic cfg_ack_o,               // Access done pulse
    output logic [31:0] cfg_rdata_o,      // Read data, valid with ack
    input wire logic io_req_i,            // I/O cycle address strobe
    input wire logic [15:0] io_addr_i,    // I/O cycle address
    input wire logic advanced_interrupt_controller_en_i,           // Advanced interrupt controller in use
    input wire logic sci_i,               // System control interrupt, active high
    output logic pm_window_hit_o,         // I/O cycle claimed by window
    output logic [6:0] pm_window_ofs_o,   // Offset within window
    output logic apm_port_hit_o,          // I/O cycle to APM port
    output logic pm_func_en_o,            // Power management function enabled
    output logic [15:0] pm_base_o,        // Current window base address
    output logic [2:0] irq_legacy_o,      // IRQ9..11, active high
    output logic [3:0] irq_advanced_interrupt_controller_n_o       // IRQ20..23, active low
);
    bca_wr_if base_b0 ();
    bca_wr_if base_b1 ();
    bca_wr_if ctrl_b0 ();

    logic cfg_wr_ok;
    logic [31:0] rdata_nxt;
    logic [15:0] io_base;
    logic decode_en;
    logic [2:0] line_sel;
    logic window_match;
    logic apm_match;
    logic [2:0] legacy_nxt;
    logic [3:0] advanced_interrupt_controller_n_nxt;

    assign cfg_wr_ok = cfg_req_i & cfg_wr_i;

    // Byte write strobes; only writable bytes get a register
    assign base_b0.we = cfg_wr_ok & (cfg_dw_i == bca_pkg::DW_IO_BASE) & cfg_be_i[0];
    assign base_b0.wdata = cfg_wdata_i[7:0];
    assign base_b1.we = cfg_wr_ok & (cfg_dw_i == bca_pkg::DW_IO_BASE) & cfg_be_i[1];
    assign base_b1.wdata = cfg_wdata_i[15:8];
    assign ctrl_b0.we = cfg_wr_ok & (cfg_dw_i == bca_pkg::DW_CONTROL) & cfg_be_i[0];
    assign ctrl_b0.wdata = cfg_wdata_i[7:0];

    // Base low byte: bit 7 writable, bit 0 held at one
    bca_byte_reg #(
        .WMASK(bca_pkg::IO_BASE_B0_WMASK),
        .RESET(bca_pkg::IO_BASE_RESET[7:0])
    ) u_base_b0 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .port(base_b0)
    );

    bca_byte_reg #(
        .WMASK(bca_pkg::IO_BASE_B1_WMASK),
        .RESET(bca_pkg::IO_BASE_RESET[15:8])
    ) u_base_b1 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .port(base_b1)
    );

    // Control: decode enable and line select; reserved bits stay zero
    bca_byte_reg #(
        .WMASK(bca_pkg::CONTROL_WMASK),
        .RESET(bca_pkg::CONTROL_RESET)
    ) u_ctrl_b0 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .port(ctrl_b0)
    );

    assign io_base = {base_b1.q, base_b0.q};
    assign decode_en = ctrl_b0.q[bca_pkg::CTRL_DECODE_EN_BIT];
    assign line_sel = ctrl_b0.q[bca_pkg::CTRL_SEL_MSB:0];

    // Read mux; unmapped dwords and reserved upper base bytes read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (cfg_dw_i)
            bca_pkg::DW_CLASS: begin
                rdata_nxt = {bca_pkg::BASE_CLASS_VALUE,
                             bca_pkg::SUB_CLASS_VALUE,
                             bca_pkg::PROGRAMMING_INTERFACE_VALUE,
                             REVISION_ID};
            end
            bca_pkg::DW_HEADER: begin
                rdata_nxt[8 * bca_pkg::LANE_HEADER +: 8] = bca_pkg::HEADER_LAYOUT_VALUE;
            end
            bca_pkg::DW_IO_BASE: begin
                rdata_nxt[15:0] = io_base;
            end
            bca_pkg::DW_CONTROL: begin
                rdata_nxt[7:0] = ctrl_b0.q;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Configuration answer one cycle after the strobe
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_ack_o <= cfg_req_i;
            if (cfg_req_i && !cfg_wr_i) begin
                cfg_rdata_o <= rdata_nxt;
            end
        end
    end

    // I/O decode: 128-byte window on the base, APM ports always
    assign window_match = io_req_i & decode_en &
                          (io_addr_i[bca_pkg::IO_BASE_MSB:bca_pkg::IO_BASE_LSB] ==
                           io_base[bca_pkg::IO_BASE_MSB:bca_pkg::IO_BASE_LSB]);
    assign apm_match = io_req_i & ((io_addr_i == bca_pkg::APM_CONTROL_PORT) |
                                   (io_addr_i == bca_pkg::APM_STATUS_PORT));

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pm_window_hit_o <= 1'b0;
            pm_window_ofs_o <= 7'h00;
            apm_port_hit_o <= 1'b0;
            pm_func_en_o <= 1'b0;
            pm_base_o <= bca_pkg::IO_BASE_RESET[15:0];
        end else begin
            pm_window_hit_o <= window_match;
            pm_window_ofs_o <= io_addr_i[bca_pkg::IO_BASE_LSB-1:0];
            apm_port_hit_o <= apm_match;
            pm_func_en_o <= decode_en;
            pm_base_o <= io_base;
        end
    end

    // Interrupt routing; legacy lines high-true, controller lines low-true and shareable
    always_comb begin
        legacy_nxt = 3'h0;
        advanced_interrupt_controller_n_nxt = 4'hf;
        if (line_sel[bca_pkg::SEL_ADVANCED_INTERRUPT_CONTROLLER_BIT]) begin
            if (advanced_interrupt_controller_en_i) begin
                advanced_interrupt_controller_n_nxt[line_sel[1:0]] = ~sci_i;
            end
        end else if (line_sel != bca_pkg::SEL_RESERVED) begin
            legacy_nxt[line_sel[1:0]] = sci_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            irq_legacy_o <= 3'h0;
            irq_advanced_interrupt_controller_n_o <= 4'hf;
        end else begin
            irq_legacy_o <= legacy_nxt;
            irq_advanced_interrupt_controller_n_o <= advanced_interrupt_controller_n_nxt;
        end
    end
endmodule : bca_config_regs

// >>> sim/bca_properties.sv
// Port checker for the configuration register bank
`timescale 1ns/1ps
module bca_properties (
    input wire logic clk_sys_i, // Clk
    input wire logic reset_i, // Rst
    input wire logic cfg_req_i, // Req
    input wire logic cfg_ack_o, // Ack
    input wire logic [31:0] cfg_rdata_o, // Rd
    input wire logic io_req_i, // Io
    input wire logic [15:0] io_addr_i, // Addr
    input wire logic advanced_interrupt_controller_en_i, // Advanced_interrupt_controller
    input wire logic sci_i, // Sci
    input wire logic pm_window_hit_o, // Win
    input wire logic [6:0] pm_window_ofs_o, // Ofs
    input wire logic apm_port_hit_o, // Apm
    input wire logic pm_func_en_o, // En
    input wire logic [15:0] pm_base_o, // Base
    input wire logic [2:0] irq_legacy_o, // Leg
    input wire logic [3:0] irq_advanced_interrupt_controller_n_o // Advanced_interrupt_controller irq
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    AST_ACK: assert property (cfg_req_i |=> cfg_ack_o) else $error("ack late");
    AST_NO_ACK: assert property (!cfg_req_i |=> !cfg_ack_o) else $error("stray ack");
    AST_RD_HOLD: assert property (!$past(cfg_req_i) && !$past(reset_i) |-> $stable(cfg_rdata_o))
        else $error("read data moved");
    AST_APM: assert property (io_req_i && io_addr_i[15:1] == 15'h0059 |=> apm_port_hit_o)
        else $error("apm miss");
    AST_APM_CAUSE: assert property (apm_port_hit_o |-> $past(io_req_i) && $past(io_addr_i[15:1]) == 15'h0059)
        else $error("apm false hit");
    AST_WIN_OFF: assert property (!pm_func_en_o ##1 !pm_func_en_o |-> !pm_window_hit_o)
        else $error("hit while off");
    AST_WIN_REQ: assert property (pm_window_hit_o |-> $past(io_req_i)) else $error("hit no req");
    AST_OFS: assert property (!$past(reset_i) |-> pm_window_ofs_o == $past(io_addr_i[6:0]))
        else $error("bad offset");
    AST_BASE: assert property (pm_base_o[6:0] == 7'h01) else $error("base low bits");
    AST_LEG: assert property (irq_legacy_o != 3'h0 |-> $past(sci_i) && $onehot(irq_legacy_o))
        else $error("legacy irq");
    AST_ADVANCED_INTERRUPT_CONTROLLER: assert property (!$past(advanced_interrupt_controller_en_i) && !$past(reset_i) |-> irq_advanced_interrupt_controller_n_o == 4'hf)
        else $error("advanced_interrupt_controller irq off");
    C_RD: cover property (cfg_ack_o);
    C_WIN: cover property (pm_window_hit_o);
    C_APM: cover property (apm_port_hit_o);
    C_ADVANCED_INTERRUPT_CONTROLLER: cover property (irq_advanced_interrupt_controller_n_o != 4'hf);
endmodule : bca_properties
bind bca_config_regs bca_properties u_prop (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_req_i(cfg_req_i),
    .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .io_req_i(io_req_i), .io_addr_i(io_addr_i),
    .advanced_interrupt_controller_en_i(advanced_interrupt_controller_en_i), .sci_i(sci_i), .pm_window_hit_o(pm_window_hit_o), .pm_base_o(pm_base_o),
    .pm_window_ofs_o(pm_window_ofs_o), .apm_port_hit_o(apm_port_hit_o), .pm_func_en_o(pm_func_en_o),
    .irq_legacy_o(irq_legacy_o), .irq_advanced_interrupt_controller_n_o(irq_advanced_interrupt_controller_n_o));

// >>> sim/bca_host_model.sv
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
module bca_host_model (
    input wire logic clk_sys_i, // Clk
    output logic cfg_req_o, // Req
    output logic cfg_wr_o, // Wr
    output logic [5:0] cfg_dw_o, // Dword
    output logic [3:0] cfg_be_o, // Enables
    output logic [31:0] cfg_wdata_o // Data
);
    initial begin
        {cfg_req_o, cfg_wr_o, cfg_dw_o, cfg_be_o, cfg_wdata_o} = '0;
    end
    task cfg(input logic w, input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_sys_i);
        {cfg_req_o, cfg_wr_o, cfg_dw_o, cfg_be_o, cfg_wdata_o} <= {1'b1, w, a, b, d};
        @(posedge clk_sys_i);
        cfg_req_o <= 1'b0;
        cfg_wdata_o <= ~d;
    endtask : cfg
endmodule : bca_host_model

// >>> sim/bca_config_regs_tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module bca_config_regs_tb;
    logic clk_sys_i, reset_i, io_req_i, advanced_interrupt_controller_en_i, sci_i, iov, en;
    logic cfg_req_i, cfg_wr_i, cfg_ack_o, pm_window_hit_o, apm_port_hit_o, pm_func_en_o;
    logic [5:0] cfg_dw_i;
    logic [3:0] cfg_be_i, irq_advanced_interrupt_controller_n_o;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, d;
    logic [15:0] io_addr_i, pm_base_o, base;
    logic [6:0] pm_window_ofs_o;
    logic [2:0] irq_legacy_o;
    logic [32:0] qc[$];
    logic [32:0] note;
    logic [31:0] qi[$];
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'he7dec937;
    bca_host_model h (.clk_sys_i(clk_sys_i), .cfg_req_o(cfg_req_i), .cfg_wr_o(cfg_wr_i), .cfg_dw_o(cfg_dw_i),
        .cfg_be_o(cfg_be_i), .cfg_wdata_o(cfg_wdata_i));
    bca_config_regs #(.REVISION_ID(8'h5a)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_dw_i(cfg_dw_i), .cfg_be_i(cfg_be_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .io_req_i(io_req_i),
        .io_addr_i(io_addr_i), .advanced_interrupt_controller_en_i(advanced_interrupt_controller_en_i), .sci_i(sci_i), .pm_window_hit_o(pm_window_hit_o),
        .pm_window_ofs_o(pm_window_ofs_o), .apm_port_hit_o(apm_port_hit_o), .pm_func_en_o(pm_func_en_o),
        .pm_base_o(pm_base_o), .irq_legacy_o(irq_legacy_o), .irq_advanced_interrupt_controller_n_o(irq_advanced_interrupt_controller_n_o));
    task end_sim;
        if (qc.size() != 0 || qi.size() != 0) begin
            n_errors++;
            $display("CHECK FAILED %0t: expected results never appeared", $time);
        end
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    task cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task cmp_rd(input logic [31:0] g, input logic [31:0] x);
        cmp(g, x);
    endtask : cmp_rd
    task cmp_io(input logic [31:0] g, input logic [31:0] x);
        cmp(g, x);
    endtask : cmp_io
    task cmp_irq(input logic [31:0] g, input logic [31:0] x);
        cmp(g, x);
    endtask : cmp_irq
    task rd(input logic [5:0] a, input logic [31:0] e);
        qc.push_back({1'b1, e});
        h.cfg(1'b0, a, 4'h0, 32'h0);
    endtask : rd
    task wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] v);
        qc.push_back(33'h0);
        h.cfg(1'b1, a, b, v);
    endtask : wr
    task io(input logic [15:0] x);
        @(posedge clk_sys_i);
        io_req_i <= 1'b1;
        io_addr_i <= x;
        qi.push_back({6'h0, en, base, en && x[15:7] == base[15:7], x[15:1] == 15'h0059, x[6:0]});
        @(posedge clk_sys_i);
        io_req_i <= 1'b0;
        io_addr_i <= ~x;
    endtask : io
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) iov <= io_req_i;
    always @(negedge clk_sys_i) begin
        if (cfg_ack_o === 1'b1 && qc.size() > 0) begin
            note = qc.pop_front();
            if (note[32]) cmp_rd(cfg_rdata_o, note[31:0]);
        end
        if (iov === 1'b1 && qi.size() > 0)
            cmp_io({6'h0, pm_func_en_o, pm_base_o, pm_window_hit_o, apm_port_hit_o, pm_window_ofs_o},
                qi.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        end_sim();
    end
    initial begin
        {reset_i, io_req_i, io_addr_i, advanced_interrupt_controller_en_i, sci_i, en, base} = {1'b1, 20'h0, 16'h1};
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(6'h02, 32'h0601005a);
        rd(6'h03, 32'h00800000);
        rd(6'h10, 32'h1);
        wr(6'h02, 4'hf, '1);
        wr(6'h03, 4'hf, '1);
        rd(6'h02, 32'h0601005a);
        rd(6'h03, 32'h00800000);
        rd(6'h3f, 32'h0);
        wr(6'h11, 4'hf, '1);
        rd(6'h11, 32'h17);
        en = 1'b1;
        repeat (6) begin
            d = $random(seed);
            wr(6'h10, 4'hf, d);
            base = {d[15:7], 7'h01};
            rd(6'h10, {16'h0, base});
            io({base[15:7], d[22:16]});
            io(d[31:16]);
            io(16'h00b2);
            io(16'h00b3);
        end
        wr(6'h10, 4'h2, 32'h0);
        base[15:8] = 8'h0;
        rd(6'h10, {16'h0, base});
        wr(6'h11, 4'h1, 32'h0);
        en = 1'b0;
        io(base);
        io(16'h00b2);
        for (int s = 0; s < 16; s++) begin
            wr(6'h11, 4'h1, {24'h0, 5'h02, s[2:0]});
            advanced_interrupt_controller_en_i <= s[3];
            sci_i <= 1'b1;
            repeat (2) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            cmp_irq({29'h0, irq_legacy_o}, (s[2:0] < 3) ? (32'h1 << s[2:0]) : 32'h0);
            cmp_irq({28'h0, irq_advanced_interrupt_controller_n_o}, (s[2] && s[3]) ? {28'h0, ~(4'h1 << s[1:0])} : 32'hf);
            @(posedge clk_sys_i);
            sci_i <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_i);
        end_sim();
    end
endmodule : bca_config_regs_tb
